// >>> tape_ctl_pkg.sv
// Purpose: shared constants for the tape unit controller
// Assumes: 50 MHz system clock, word-indexed register port
// Notes:   timing counts derive from the times in ns
// Contract
// - one write strobe per recorded character, each at least 2 us wide
// - write parity and data held stable during strobe and 0.5 us around it
// - nine-track: extra strobe carries cyclic check char four spaces after last data
// - pulse write register clear 8 spaces (nine) or 4 spaces (seven) after data
// - threshold select held through each record, high only for read-after-write checks
// - controller ignores read track lines while writing or before tape is up to speed
// - controller times pre-record and post-record delays before and after records
// - go-local and rewind commands separated by at least 2 us
// - unit read strobe at least 2 us per char; sample on its trailing edge
// - rewind pulse at least 2 us; ignored at beginning marker or not ready
// - write status set before motion, kept until motion stops; gates write current
package tape_ctl_pkg;

  // register map, word index on the address port
  localparam int          ADDR_W   = 4;
  localparam int          DATA_W   = 16;
  localparam logic [3:0]  A_CTRL   = 4'h0;
  localparam logic [3:0]  A_CMD    = 4'h1;
  localparam logic [3:0]  A_WDATA  = 4'h2;
  localparam logic [3:0]  A_CHECK  = 4'h3;
  localparam logic [3:0]  A_STATUS = 4'h4;
  localparam logic [3:0]  A_RDATA  = 4'h5;

  // control register fields
  localparam int          C_SEL    = 0;
  localparam int          C_WSTAT  = 1;
  localparam int          C_FWD    = 2;
  localparam int          C_THR    = 3;
  localparam int          C_NINE   = 4;
  localparam int          C_RDEN   = 5;
  localparam int          CTRL_W   = 6;
  localparam logic [5:0]  CTRL_RST = 6'h00;

  // command register fields, write one to act
  localparam int          K_EOR    = 0;
  localparam int          K_REW    = 1;
  localparam int          K_OFF    = 2;

  // status register fields
  localparam int          S_RDY    = 0;
  localparam int          S_LDP    = 1;
  localparam int          S_EOT    = 2;
  localparam int          S_FPT    = 3;
  localparam int          S_RWD    = 4;
  localparam int          S_ONL    = 5;
  localparam int          S_DEN    = 6;
  localparam int          S_BUSY   = 7;
  localparam int          S_RXV    = 8;
  localparam int          S_RUN    = 9;

  // character word: parity in bit 8, tracks below
  localparam int          CHAR_W   = 9;
  localparam int          TRK_W    = 8;

  // timing
  localparam int          CLK_NS     = 20;
  localparam int          STROBE_NS  = 2000;
  localparam int          SETUP_NS   = 500;
  localparam int          GAP_NS     = 2000;
  localparam logic [7:0]  STROBE_CYC = 8'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  SETUP_CYC  = 8'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  GAP_CYC    = 8'((GAP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [8:0]  PULSE_TOT  = 9'({1'b0, STROBE_CYC} + {1'b0, GAP_CYC});

  // character spaces after the last data character
  localparam logic [3:0]  CRC_SPACES  = 4'h4;
  localparam logic [3:0]  CLR_SPACES9 = 4'h8;
  localparam logic [3:0]  CLR_SPACES7 = 4'h4;

  typedef enum logic [1:0] {W_IDLE, W_SETUP, W_STROBE, W_HOLD} wr_state_t;
  typedef enum logic [1:0] {M_STOP, M_PRE, M_RUN, M_POST} motion_t;

endpackage

// >>> pin_sync.sv
// Purpose: three-stage synchroniser for pins from the tape unit
// Assumes: inputs asynchronous to clk_i
// Notes:   output follows once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // shift chain, first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // accept a change per bit once stages agree
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      level_o <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          level_o[i] <= s3_reg[i];
        end
      end
    end
  end

endmodule

// >>> tape_ctl.sv
// Purpose: controller driving a tape unit through its interface pins
// Assumes: software sets up motion and feeds characters at the char rate
// Notes:   long tape-travel delays are parameters for fast simulation
`timescale 1ns/1ps
module tape_ctl #(
  parameter logic [15:0] CHAR_CYC    = 16'd5000,
  parameter logic [23:0] PRE_BOT_CYC = 24'd14000000,
  parameter logic [23:0] PRE9_CYC    = 24'd1600000,
  parameter logic [23:0] PRE7_CYC    = 24'd2040000,
  parameter logic [23:0] POST_CYC    = 24'd300000
) (
  input  wire logic                             clk_i,
  input  wire logic                             sys_rst_i,
  input  wire logic [tape_ctl_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [tape_ctl_pkg::DATA_W-1:0]  wdata_i,
  input  wire logic                             wr_i,
  input  wire logic                             rd_i,
  output logic      [tape_ctl_pkg::DATA_W-1:0]  rdata_o,
  output logic                                  unit_select_o,
  output logic                                  write_char_strobe_o,
  output logic                                  write_parity_line_o,
  output logic      [tape_ctl_pkg::TRK_W-1:0]   write_track_lines_o,
  output logic                                  write_register_clear_o,
  output logic                                  read_threshold_select_o,
  output logic                                  forward_motion_level_o,
  output logic                                  write_status_level_o,
  output logic                                  rewind_pulse_o,
  output logic                                  go_local_command_o,
  input  wire logic                             ready_i,
  input  wire logic                             load_point_level_i,
  input  wire logic                             end_marker_level_i,
  input  wire logic                             write_protect_level_i,
  input  wire logic                             rewinding_level_i,
  input  wire logic                             online_i,
  input  wire logic                             density_indicator_i,
  input  wire logic                             read_char_strobe_i,
  input  wire logic                             read_parity_pulse_i,
  input  wire logic [tape_ctl_pkg::TRK_W-1:0]   read_track_pulses_i
);
  import tape_ctl_pkg::*;

  logic [CTRL_W-1:0]  ctrl_reg;
  logic [CHAR_W-1:0]  check_reg;
  logic [16:0]        pins;
  logic               ready_s, ldp_s, rds_s, rds_prev_reg;
  logic [CHAR_W-1:0]  rd_bits_s;
  wr_state_t          w_state;
  logic [7:0]         w_cnt;
  logic               is_check_reg;
  motion_t            motion;
  logic [23:0]        m_cnt;
  logic [15:0]        char_cnt;
  logic [3:0]         spaces_reg;
  logic               last_valid_reg, eor_reg, crc_done_reg;
  logic [7:0]         clr_cnt;
  logic [8:0]         p_cnt;
  logic [CHAR_W-1:0]  acc_reg, rx_reg;
  logic               rxv_reg;
  logic               wr_cmd, read_ok, rds_fall, data_fall, launch_data, launch_chk;
  logic               start_clr;
  logic [3:0]         clr_spaces;

  // pin inputs through the synchroniser
  pin_sync #(.W(17)) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     ({read_parity_pulse_i, read_track_pulses_i, read_char_strobe_i,
                 density_indicator_i, online_i, rewinding_level_i,
                 write_protect_level_i, end_marker_level_i, load_point_level_i, ready_i}),
    .level_o   (pins)
  );
  assign ready_s   = pins[0];
  assign ldp_s     = pins[1];
  assign rds_s     = pins[7];
  assign rd_bits_s = pins[16:8];

  // pre-record travel depends on start position and track count
  function automatic logic [23:0] pre_count(input logic at_bot, input logic nine);
    if (at_bot) begin
      pre_count = PRE_BOT_CYC;
    end else if (nine) begin
      pre_count = PRE9_CYC;
    end else begin
      pre_count = PRE7_CYC;
    end
  endfunction

  // request decode
  assign wr_cmd      = wr_i && (addr_i == A_CMD);
  assign launch_data = wr_i && (addr_i == A_WDATA) && (w_state == W_IDLE) &&
                       (motion == M_RUN) && write_status_level_o && !eor_reg;
  assign launch_chk  = eor_reg && ctrl_reg[C_NINE] && !crc_done_reg &&
                       (spaces_reg >= CRC_SPACES) && (w_state == W_IDLE);
  assign data_fall   = (w_state == W_STROBE) && (w_cnt == 8'h00) && !is_check_reg;
  assign clr_spaces  = ctrl_reg[C_NINE] ? CLR_SPACES9 : CLR_SPACES7;
  assign start_clr   = eor_reg && !write_register_clear_o && (clr_cnt == 8'h00) &&
                       (spaces_reg >= clr_spaces) && (w_state == W_IDLE) &&
                       (crc_done_reg || !ctrl_reg[C_NINE]);
  assign read_ok     = ctrl_reg[C_RDEN] && !write_status_level_o && (motion == M_RUN);
  assign rds_fall    = rds_prev_reg && !rds_s;

  // software registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_reg  <= CTRL_RST;
      check_reg <= '0;
    end else if (wr_i && (addr_i == A_CTRL)) begin
      ctrl_reg <= wdata_i[CTRL_W-1:0];
    end else if (wr_i && (addr_i == A_CHECK)) begin
      check_reg <= wdata_i[CHAR_W-1:0];
    end
  end

  // select and threshold; threshold only changes with tape stopped
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      unit_select_o           <= 1'b0;
      read_threshold_select_o <= 1'b0;
    end else begin
      unit_select_o <= ctrl_reg[C_SEL];
      if (motion == M_STOP) begin
        read_threshold_select_o <= ctrl_reg[C_THR];
      end
    end
  end

  // write status rises at once, falls only with tape stopped
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      write_status_level_o <= 1'b0;
    end else if (ctrl_reg[C_WSTAT]) begin
      write_status_level_o <= 1'b1;
    end else if (!forward_motion_level_o) begin
      write_status_level_o <= 1'b0;
    end
  end

  // forward motion with pre-record and post-record delays
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      motion                 <= M_STOP;
      m_cnt                  <= '0;
      forward_motion_level_o <= 1'b0;
    end else begin
      case (motion)
        M_STOP: begin
          if (ctrl_reg[C_FWD] && ready_s &&
              (write_status_level_o || !ctrl_reg[C_WSTAT])) begin
            motion                 <= M_PRE;
            m_cnt                  <= pre_count(ldp_s, ctrl_reg[C_NINE]);
            forward_motion_level_o <= 1'b1;
          end
        end
        M_PRE: begin
          if (m_cnt == 24'h00_0000) begin
            motion <= M_RUN;
          end else begin
            m_cnt <= m_cnt - 24'h00_0001;
          end
        end
        M_RUN: begin
          if (!ctrl_reg[C_FWD] && (w_state == W_IDLE) && !eor_reg) begin
            motion <= M_POST;
            m_cnt  <= POST_CYC;
          end
        end
        M_POST: begin
          if (m_cnt == 24'h00_0000) begin
            motion                 <= M_STOP;
            forward_motion_level_o <= 1'b0;
          end else begin
            m_cnt <= m_cnt - 24'h00_0001;
          end
        end
        default: motion <= M_STOP;
      endcase
      if (!ready_s && (motion != M_STOP)) begin
        motion                 <= M_STOP;
        forward_motion_level_o <= 1'b0;
      end
    end
  end

  // character strobe engine: setup, strobe, hold
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      w_state             <= W_IDLE;
      w_cnt               <= '0;
      is_check_reg        <= 1'b0;
      write_char_strobe_o <= 1'b0;
      write_parity_line_o <= 1'b0;
      write_track_lines_o <= '0;
    end else begin
      case (w_state)
        W_IDLE: begin
          if (launch_chk) begin
            {write_parity_line_o, write_track_lines_o} <= check_reg;
            is_check_reg <= 1'b1;
            w_state      <= W_SETUP;
            w_cnt        <= SETUP_CYC - 8'h01;
          end else if (launch_data) begin
            {write_parity_line_o, write_track_lines_o} <= wdata_i[CHAR_W-1:0];
            is_check_reg <= 1'b0;
            w_state      <= W_SETUP;
            w_cnt        <= SETUP_CYC - 8'h01;
          end
        end
        W_SETUP: begin
          if (w_cnt == 8'h00) begin
            w_state             <= W_STROBE;
            w_cnt               <= STROBE_CYC - 8'h01;
            write_char_strobe_o <= 1'b1;
          end else begin
            w_cnt <= w_cnt - 8'h01;
          end
        end
        W_STROBE: begin
          if (w_cnt == 8'h00) begin
            w_state             <= W_HOLD;
            w_cnt               <= SETUP_CYC - 8'h01;
            write_char_strobe_o <= 1'b0;
          end else begin
            w_cnt <= w_cnt - 8'h01;
          end
        end
        W_HOLD: begin
          if (w_cnt == 8'h00) begin
            w_state <= W_IDLE;
          end else begin
            w_cnt <= w_cnt - 8'h01;
          end
        end
        default: w_state <= W_IDLE;
      endcase
    end
  end

  // character spaces since the last data strobe
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      char_cnt   <= '0;
      spaces_reg <= 4'hf;
    end else if (data_fall) begin
      char_cnt   <= '0;
      spaces_reg <= 4'h0;
    end else if (spaces_reg != 4'hf) begin
      if (char_cnt == CHAR_CYC - 16'h0001) begin
        char_cnt   <= '0;
        spaces_reg <= spaces_reg + 4'h1;
      end else begin
        char_cnt <= char_cnt + 16'h0001;
      end
    end
  end

  // end of record: check character (nine-track only) then write register clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      last_valid_reg         <= 1'b0;
      eor_reg                <= 1'b0;
      crc_done_reg           <= 1'b0;
      clr_cnt                <= '0;
      write_register_clear_o <= 1'b0;
    end else begin
      if (data_fall) begin
        last_valid_reg <= 1'b1;
      end
      if (wr_cmd && wdata_i[K_EOR] && !eor_reg && last_valid_reg) begin
        eor_reg <= 1'b1;
      end
      if (launch_chk) begin
        crc_done_reg <= 1'b1;
      end
      if (start_clr) begin
        write_register_clear_o <= 1'b1;
        clr_cnt                <= STROBE_CYC;
      end else if (clr_cnt != 8'h00) begin
        clr_cnt <= clr_cnt - 8'h01;
        if (clr_cnt == 8'h01) begin
          write_register_clear_o <= 1'b0;
          eor_reg                <= 1'b0;
          crc_done_reg           <= 1'b0;
          last_valid_reg         <= 1'b0;
        end
      end
    end
  end

  // rewind and go-local pulses, each followed by a quiet gap
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      p_cnt              <= '0;
      rewind_pulse_o     <= 1'b0;
      go_local_command_o <= 1'b0;
    end else if (p_cnt == 9'h000) begin
      if (wr_cmd && wdata_i[K_REW] && ready_s && !ldp_s) begin
        rewind_pulse_o <= 1'b1;
        p_cnt          <= PULSE_TOT;
      end else if (wr_cmd && wdata_i[K_OFF]) begin
        go_local_command_o <= 1'b1;
        p_cnt              <= PULSE_TOT;
      end
    end else begin
      p_cnt <= p_cnt - 9'h001;
      if (p_cnt == {1'b0, GAP_CYC} + 9'h001) begin
        rewind_pulse_o     <= 1'b0;
        go_local_command_o <= 1'b0;
      end
    end
  end

  // read capture: gather bit pulses, take char on strobe trailing edge
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rds_prev_reg <= 1'b0;
      acc_reg      <= '0;
      rx_reg       <= '0;
      rxv_reg      <= 1'b0;
    end else begin
      rds_prev_reg <= rds_s;
      if (!read_ok) begin
        acc_reg <= '0;
      end else if (rds_fall) begin
        rx_reg  <= acc_reg | rd_bits_s;
        acc_reg <= '0;
      end else begin
        acc_reg <= acc_reg | rd_bits_s;
      end
      if (read_ok && rds_fall) begin
        rxv_reg <= 1'b1;
      end else if (rd_i && (addr_i == A_RDATA)) begin
        rxv_reg <= 1'b0;
      end
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= '0;
    end else if (!rd_i) begin
      rdata_o <= '0;
    end else if (addr_i == A_CTRL) begin
      rdata_o <= {10'h000, ctrl_reg};
    end else if (addr_i == A_CHECK) begin
      rdata_o <= {7'h00, check_reg};
    end else if (addr_i == A_STATUS) begin
      rdata_o <= {6'h00, (motion == M_RUN), rxv_reg,
                  ((w_state != W_IDLE) || eor_reg || (p_cnt != 9'h000)), pins[6:0]};
    end else if (addr_i == A_RDATA) begin
      rdata_o <= {7'h00, rx_reg};
    end else begin
      rdata_o <= '0;
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  logic [7:0] strb_len, quiet_len;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      strb_len  <= '0;
      quiet_len <= 8'hff;
    end else begin
      strb_len  <= write_char_strobe_o ? strb_len + 8'h01 : 8'h00;
      quiet_len <= (rewind_pulse_o || go_local_command_o) ? 8'h00 :
                   (quiet_len == 8'hff) ? quiet_len : quiet_len + 8'h01;
    end
  end

  AST_STROBE_WIDTH: assert property ($fell(write_char_strobe_o) |->
    strb_len == STROBE_CYC) else $error("write strobe width wrong");
  AST_DATA_STABLE: assert property ((w_state != W_IDLE) && ($past(w_state) != W_IDLE) |->
    $stable({write_parity_line_o, write_track_lines_o})) else $error("write data moved");
  AST_CRC_SPACE: assert property ($rose(write_char_strobe_o) && is_check_reg |->
    spaces_reg == CRC_SPACES) else $error("check char at wrong space");
  AST_CLR_SPACE: assert property ($rose(write_register_clear_o) |->
    spaces_reg == clr_spaces ##1 write_register_clear_o[*8]) else $error("clear misplaced");
  AST_THR_STABLE: assert property ((motion != M_STOP) && ($past(motion) != M_STOP) |->
    $stable(read_threshold_select_o)) else $error("threshold moved in record");
  AST_READ_GATED: assert property ($rose(rxv_reg) |-> $past(read_ok))
    else $error("read taken while gated");
  AST_RDS_EDGE: assert property ($rose(rxv_reg) |-> $past(rds_fall))
    else $error("read not on strobe trailing edge");
  AST_CMD_GAP: assert property ($rose(rewind_pulse_o) || $rose(go_local_command_o) |->
    $past(quiet_len) >= GAP_CYC) else $error("command gap too short");
  AST_REWIND_GATE: assert property ($rose(rewind_pulse_o) |->
    $past(ready_s && !ldp_s)) else $error("rewind issued while barred");
  AST_WSTAT_FIRST: assert property ($rose(forward_motion_level_o) && ctrl_reg[C_WSTAT] |->
    write_status_level_o) else $error("motion before write status");
  AST_WSTAT_HOLD: assert property ($fell(write_status_level_o) |->
    !forward_motion_level_o) else $error("write status dropped in motion");
  AST_POST_DELAY: assert property ($fell(forward_motion_level_o) && ready_s |->
    $past(motion) == M_POST) else $error("motion dropped without post delay");

  COV_DATA_CHAR: cover property ($fell(write_char_strobe_o) && !is_check_reg);
  COV_CHECK_CHAR: cover property ($rose(write_char_strobe_o) && is_check_reg);
  COV_CLEAR: cover property ($fell(write_register_clear_o));
  COV_READ_CHAR: cover property ($rose(rxv_reg));

endmodule

// >>> tape_unit.sv
// Purpose: behavioural tape unit on the far side of the controller
// Assumes: tape tensioned, loaded and online at start, reel at load point
// Notes:   levels read false while deselected, as pulled-up lines do
`timescale 1ns/1ps
module tape_unit (
  input  wire logic       sel_i,
  input  wire logic       wcs_i,
  input  wire logic [8:0] wchar_i,
  input  wire logic       wclr_i,
  input  wire logic       fwd_i,
  input  wire logic       wst_i,
  input  wire logic       rew_i,
  input  wire logic       gol_i,
  output logic            ready_o,
  output logic            ldp_o,
  output logic            rwd_o,
  output logic            onl_o,
  output logic            rds_o,
  output logic      [8:0] rbits_o
);
  logic [8:0] wreg = '0, longitudinal_check_char = '0, rch = '0;
  logic       online = 1, at_bot = 1, rewinding_level = 0, read_char_strobe = 0;
  int         err = 0, nstr = 0, nclr = 0;
  realtime    t_up = -1e6, t_dn = -1e6, t_chg = -1e6, t_clr = 0;
  wire        ready = online & !rewinding_level;
  // outputs gated by select
  assign ready_o = sel_i & ready;
  assign ldp_o   = sel_i & ready & at_bot;
  assign rwd_o   = sel_i & rewinding_level;
  assign onl_o   = sel_i & online;
  assign rds_o   = sel_i & read_char_strobe;
  assign rbits_o = sel_i ? rch : '0;
  // data must be settled before the strobe and held after it
  always @(wchar_i) begin
    if (sel_i && (wcs_i || $realtime - t_dn < 500)) err++;
    t_chg = $realtime;
  end
  always @(posedge wcs_i) begin
    t_up = $realtime;
    if (sel_i && t_up - t_chg < 500) err++;
  end
  // trailing edge toggles the write register
  always @(negedge wcs_i) begin
    t_dn = $realtime;
    if (sel_i && t_dn - t_up < 2000) err++;
    if (sel_i && wst_i && ready) begin
      wreg ^= wchar_i;
      nstr++;
    end
  end
  // clear pulse records the longitudinal check, then empties the register
  always @(posedge wclr_i) begin
    t_clr = $realtime;
    longitudinal_check_char = wreg;
    nclr++;
  end
  always @(negedge wclr_i) begin
    if (sel_i && $realtime - t_clr < 2000) err++;
    wreg = '0;
  end
  // rewind back to load point
  always @(posedge rew_i) begin
    if (sel_i && ready && !at_bot) begin
      rewinding_level = 1;
      #3000 at_bot = 1;
      rewinding_level = 0;
    end
  end
  // offline command acts on select alone
  always @(posedge gol_i) if (sel_i) online = 0;
  // forward motion carries the tab off the sensor
  always @(posedge fwd_i) if (sel_i && ready) #1000 at_bot = 0;
  // one character from tape: bit pulses, then the strobe
  task automatic send(input logic [8:0] c);
    rch = c;
    #1000 rch = '0;
    #200 read_char_strobe = 1;
    #2400 read_char_strobe = 0;
  endtask
endmodule

// >>> tape_unit_host_interface_bench.sv
// Purpose: register-level bench for the tape unit controller
// Assumes: shortened tape delays, unit model on the far side
// Notes:   one record in nine-track, one in seven-track mode
`timescale 1ns/1ps
module tape_unit_host_interface_bench;
  import tape_ctl_pkg::*;
  logic        clk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0;
  logic [3:0]  addr_i = '0;
  logic [15:0] wdata_i = '0, rdata_o, s, d;
  logic        sel, wcs, wpar, wclr, fwd, wst, rew, gol, rdy, load_point_level, rewinding_level, onl, read_char_strobe, thr;
  logic        end_marker_level = 0, write_protect_level = 0, den = 0;
  logic [7:0]  wtrk;
  logic [8:0]  rbits;
  int          failures = 0, checked = 0, n0;
  realtime     t0;
  tape_ctl #(.CHAR_CYC(16'h28), .PRE_BOT_CYC(24'h32), .PRE9_CYC(24'h1E), .PRE7_CYC(24'h1E),
    .POST_CYC(24'h14)) u_tape_ctl (.clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .unit_select_o(sel), .write_char_strobe_o(wcs), .write_parity_line_o(wpar),
    .write_track_lines_o(wtrk), .write_register_clear_o(wclr), .read_threshold_select_o(thr),
    .forward_motion_level_o(fwd), .write_status_level_o(wst), .rewind_pulse_o(rew),
    .go_local_command_o(gol), .ready_i(rdy), .load_point_level_i(load_point_level),
    .end_marker_level_i(end_marker_level), .write_protect_level_i(write_protect_level), .rewinding_level_i(rewinding_level),
    .online_i(onl), .density_indicator_i(den), .read_char_strobe_i(read_char_strobe),
    .read_parity_pulse_i(rbits[8]), .read_track_pulses_i(rbits[7:0]));
  tape_unit u_tape_unit (.sel_i(sel), .wcs_i(wcs), .wchar_i({wpar, wtrk}), .wclr_i(wclr),
    .fwd_i(fwd), .wst_i(wst), .rew_i(rew), .gol_i(gol), .ready_o(rdy), .ldp_o(load_point_level),
    .rwd_o(rewinding_level), .onl_o(onl), .rds_o(read_char_strobe), .rbits_o(rbits));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // register port cycles
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    v = rdata_o;
  endtask
  task automatic chk(input logic [15:0] g, e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // poll one status bit, bounded
  task automatic waitst(input int b, input logic v);
    rd(A_STATUS, s);
    for (int n = 0; n < 3000 && s[b] !== v; n++) rd(A_STATUS, s);
    chk(16'(s[b]), 16'(v));
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #2000000;
    failures++;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(A_CTRL, d);
    chk(d, 16'h0000);
    rd(4'hF, d);
    chk(d, 16'h0000);
    waitst(S_ONL, 0);
    wr(A_CTRL, 16'h0001);
    waitst(S_ONL, 1);
    waitst(S_LDP, 1);
    wr(A_CMD, 16'h0002);
    repeat (10) @(posedge clk_i);
    rd(A_STATUS, s);
    chk(16'({s[S_RWD], s[S_BUSY]}), 16'h0000);
    wr(A_CHECK, 16'h00C3);
    // one record per track mode
    for (int m = 1; m >= 0; m--) begin
      wr(A_CTRL, 16'h0007 | 16'(m << C_NINE));
      waitst(S_RUN, 1);
      n0 = u_tape_unit.nstr;
      wr(A_WDATA, 16'h01A5);
      waitst(S_BUSY, 0);
      chk(16'(u_tape_unit.wreg), 16'h01A5);
      wr(A_WDATA, 16'h00F0);
      waitst(S_BUSY, 0);
      t0 = u_tape_unit.t_dn;
      wr(A_CMD, 16'h0001);
      for (int n = 0; n < 2000 && (u_tape_unit.nclr != 2 - m || wclr); n++) @(posedge clk_i);
      chk(16'(u_tape_unit.nstr - n0), 16'(2 + m));
      chk(16'(u_tape_unit.longitudinal_check_char), m ? 16'h0196 : 16'h0155);
      chk(16'(u_tape_unit.wreg), 16'h0000);
      chk(16'(int'((u_tape_unit.t_clr - t0) / 20) / 8), m ? 16'h0028 : 16'h0014);
    end
    waitst(S_LDP, 0);
    wr(A_CTRL, 16'h0001);
    waitst(S_RUN, 0);
    wr(A_CMD, 16'h0002);
    waitst(S_RWD, 1);
    chk(16'(s[S_RDY]), 16'h0000);
    waitst(S_LDP, 1);
    wr(A_CTRL, 16'h0025);
    waitst(S_RUN, 1);
    u_tape_unit.send(9'h12C);
    waitst(S_RXV, 1);
    rd(A_RDATA, d);
    chk(d, 16'h012C);
    wr(A_CTRL, 16'h0009);
    repeat (10) @(negedge clk_i);
    chk(16'(thr), 16'h0000);
    repeat (30) @(negedge clk_i);
    chk(16'(thr), 16'h0001);
    waitst(S_BUSY, 0);
    wr(A_CMD, 16'h0004);
    waitst(S_ONL, 0);
    chk(16'(s[S_RDY]), 16'h0000);
    chk(16'(u_tape_unit.err), 16'h0000);
    // unit status levels reach their own status bits
    @(posedge clk_i);
    {den, write_protect_level, end_marker_level} <= 3'b101;
    repeat (8) @(posedge clk_i);
    rd(A_STATUS, s);
    chk(16'({s[S_DEN], s[S_FPT], s[S_EOT]}), 16'h0005);
    @(posedge clk_i);
    {den, write_protect_level, end_marker_level} <= 3'b010;
    repeat (8) @(posedge clk_i);
    rd(A_STATUS, s);
    chk(16'({s[S_DEN], s[S_FPT], s[S_EOT]}), 16'h0002);
    report_and_stop;
  end
endmodule
